// *** verilog/sle_top.sv ***
// switching logic fabric: eight toggle latches, eight lookup-table logic
// elements, one alarm driver and the source selector, behind ahb-lite.
// assumes the single ahb master sees hreadyout as hready; other function
// outputs and breaker flags arrive on sys_clk_in, event and discrete pins
// are asynchronous.
//
// Contract
// - eight toggle latches, outputs selectable as sources one to eight.
// - rising toggle input inverts output; falling input leaves it alone.
// - toggle element configuration is only its input source selection.
// - eight logic elements, each combining three selectable inputs.
// - each logic element holds an eight-entry programmable table.
// - logic output equals the table entry its inputs pick, next cycle.
// - logic outputs are selectable sources for any element input.
// - exactly one alarm driver, power and ground switched together.
// - alarm active drives power and ground; else both float.
// - the no-source selection reads as constant low.
// - each of twelve event inputs offers low, float and high sources.
// - sixteen network inputs and sixteen discrete i/o are sources.
// - logic, latch, toggle, timer, flash, counter outputs are sources.
// - per breaker channel: overcurrent, tripped, thermal flags are sources.
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
`timescale 1ns/1ps
module sle_top (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // asynchronous pins
   input wire logic [sle_pkg::N_BE-1:0] be_low_in,
   input wire logic [sle_pkg::N_BE-1:0] be_float_in,
   input wire logic [sle_pkg::N_BE-1:0] be_high_in,
   input wire logic [sle_pkg::N_DIO-1:0] dio_in,
   // same-clock sources
   input wire logic [sle_pkg::N_NET-1:0] net_in,
   input wire logic [sle_pkg::N_FUNC-1:0] latch_in,
   input wire logic [sle_pkg::N_FUNC-1:0] timer_in,
   input wire logic [sle_pkg::N_FUNC-1:0] flash_in,
   input wire logic [sle_pkg::N_FUNC-1:0] count_act_in,
   input wire logic [sle_pkg::N_CH-1:0] oc_fault_in,
   input wire logic [sle_pkg::N_CH-1:0] tripped_in,
   input wire logic [sle_pkg::N_CH-1:0] therm_in,
   // element outputs
   output logic [sle_pkg::N_TOG-1:0] toggle_out,
   output logic [sle_pkg::N_LOG-1:0] logic_out,
   // alarm driver
   output logic alarm_pwr_out,
   output logic alarm_pwr_oe_b_out,
   output logic alarm_gnd_out,
   output logic alarm_gnd_oe_b_out
);
   localparam int BE3 = 3 * sle_pkg::N_BE;

   logic [BE3-1:0] be_meta;
   logic [BE3-1:0] be_sync;
   logic [sle_pkg::N_DIO-1:0] dio_meta;
   logic [sle_pkg::N_DIO-1:0] dio_sync;
   logic [sle_pkg::SRC_NUM-1:0] src_vec;
   logic [sle_pkg::SEL_W-1:0] tog_sel [sle_pkg::N_TOG];
   logic [31:0] log_cfg [sle_pkg::N_LOG];
   logic [sle_pkg::SEL_W-1:0] alm_sel;
   logic alarm_on;
   logic next_alarm_on;
   logic wr_pend;
   logic rd_pend;
   logic [11:0] dp_addr;
   logic [31:0] rd_word;
   logic take;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // out-of-range selections read low like the no-source choice
   function automatic logic pick(input logic [sle_pkg::SRC_NUM-1:0] v,
                                 input logic [sle_pkg::SEL_W-1:0] s);
      pick = (int'(s) < sle_pkg::SRC_NUM) ? v[s] : 1'b0;
   endfunction

   function automatic logic [11:0] reg_ofs(input logic [11:0] base,
                                           input int i);
      reg_ofs = base + 12'(i * sle_pkg::OFS_STEP);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         be_meta <= '0;
         be_sync <= '0;
         dio_meta <= '0;
         dio_sync <= '0;
      end else begin
         be_meta <= {be_high_in, be_float_in, be_low_in};
         be_sync <= be_meta;
         dio_meta <= dio_in;
         dio_sync <= dio_meta;
      end
   end

   // ---------------------------------------------------------------
   // source vector
   // ---------------------------------------------------------------
   always_comb begin
      src_vec = '0;
      src_vec[sle_pkg::SRC_NONE] = 1'b0;
      src_vec[sle_pkg::SRC_BE_LO +: sle_pkg::N_BE] =
         be_sync[0 +: sle_pkg::N_BE];
      src_vec[sle_pkg::SRC_BE_FL +: sle_pkg::N_BE] =
         be_sync[sle_pkg::N_BE +: sle_pkg::N_BE];
      src_vec[sle_pkg::SRC_BE_HI +: sle_pkg::N_BE] =
         be_sync[2 * sle_pkg::N_BE +: sle_pkg::N_BE];
      src_vec[sle_pkg::SRC_NET +: sle_pkg::N_NET] = net_in;
      src_vec[sle_pkg::SRC_LOG +: sle_pkg::N_LOG] = logic_out;
      src_vec[sle_pkg::SRC_LAT +: sle_pkg::N_FUNC] = latch_in;
      src_vec[sle_pkg::SRC_TOG +: sle_pkg::N_TOG] = toggle_out;
      src_vec[sle_pkg::SRC_TMR +: sle_pkg::N_FUNC] = timer_in;
      src_vec[sle_pkg::SRC_FLS +: sle_pkg::N_FUNC] = flash_in;
      src_vec[sle_pkg::SRC_CNT +: sle_pkg::N_FUNC] = count_act_in;
      src_vec[sle_pkg::SRC_OC +: sle_pkg::N_CH] = oc_fault_in;
      src_vec[sle_pkg::SRC_TRP +: sle_pkg::N_CH] = tripped_in;
      src_vec[sle_pkg::SRC_THM +: sle_pkg::N_CH] = therm_in;
      src_vec[sle_pkg::SRC_DIO +: sle_pkg::N_DIO] = dio_sync;
   end

   // ---------------------------------------------------------------
   // elements
   // ---------------------------------------------------------------
   for (genvar i = 0; i < sle_pkg::N_TOG; i++) begin : g_tog
      sle_toggle u_tog (
         .sys_clk_in(sys_clk_in),
         .rst_b_in(rst_b_in),
         .toggle_in(pick(src_vec, tog_sel[i])),
         .toggle_out(toggle_out[i])
      );
   end

   for (genvar i = 0; i < sle_pkg::N_LOG; i++) begin : g_log
      sle_lut u_lut (
         .sys_clk_in(sys_clk_in),
         .rst_b_in(rst_b_in),
         .a_in(pick(src_vec, log_cfg[i][sle_pkg::FLD_A +: 8])),
         .b_in(pick(src_vec, log_cfg[i][sle_pkg::FLD_B +: 8])),
         .c_in(pick(src_vec, log_cfg[i][sle_pkg::FLD_C +: 8])),
         .lut_in(log_cfg[i][sle_pkg::FLD_LUT +: sle_pkg::LUT_W]),
         .lut_out(logic_out[i])
      );
   end

   // ---------------------------------------------------------------
   // alarm driver
   // ---------------------------------------------------------------
   assign next_alarm_on = pick(src_vec, alm_sel);

   // both terminals switch from next_alarm_on on the same edge so they never split
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         alarm_on <= 1'b0;
         alarm_pwr_out <= 1'b0;
         alarm_gnd_out <= 1'b0;
         alarm_pwr_oe_b_out <= 1'b1;
         alarm_gnd_oe_b_out <= 1'b1;
      end else begin
         alarm_on <= next_alarm_on;
         alarm_pwr_out <= next_alarm_on;
         alarm_gnd_out <= 1'b0;
         alarm_pwr_oe_b_out <= ~next_alarm_on;
         alarm_gnd_oe_b_out <= ~next_alarm_on;
      end
   end

   // ---------------------------------------------------------------
   // ahb-lite slave
   // ---------------------------------------------------------------
   // only whole-word transfers are acted on; other sizes answer okay
   assign take = hsel_in && hready_in && htrans_in[sle_pkg::HTRANS_ACT]
                 && (hsize_in == sle_pkg::HSIZE_WORD);

   // reads take one wait state so a read right after a write sees it
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= '0;
         hreadyout_out <= 1'b1;
      end else begin
         wr_pend <= take && hwrite_in;
         rd_pend <= take && !hwrite_in;
         hreadyout_out <= !(take && !hwrite_in);
         if (take) begin
            dp_addr <= haddr_in[11:0];
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hresp_out <= sle_pkg::HRESP_OKAY;
      end else begin
         hresp_out <= sle_pkg::HRESP_OKAY;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < sle_pkg::N_TOG; i++) begin
            tog_sel[i] <= sle_pkg::SEL_RST;
         end
      end else if (wr_pend) begin
         for (int i = 0; i < sle_pkg::N_TOG; i++) begin
            if (dp_addr == reg_ofs(sle_pkg::OFS_TOG_SEL, i)) begin
               tog_sel[i] <= hwdata_in[sle_pkg::SEL_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < sle_pkg::N_LOG; i++) begin
            log_cfg[i] <= sle_pkg::CFG_RST;
         end
      end else if (wr_pend) begin
         for (int i = 0; i < sle_pkg::N_LOG; i++) begin
            if (dp_addr == reg_ofs(sle_pkg::OFS_LOG_CFG, i)) begin
               log_cfg[i] <= hwdata_in;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         alm_sel <= sle_pkg::SEL_RST;
      end else if (wr_pend && dp_addr == sle_pkg::OFS_ALM_SEL) begin
         alm_sel <= hwdata_in[sle_pkg::SEL_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_word = '0;
      for (int i = 0; i < sle_pkg::N_TOG; i++) begin
         if (dp_addr == reg_ofs(sle_pkg::OFS_TOG_SEL, i)) begin
            rd_word = {24'h00_0000, tog_sel[i]};
         end
      end
      for (int i = 0; i < sle_pkg::N_LOG; i++) begin
         if (dp_addr == reg_ofs(sle_pkg::OFS_LOG_CFG, i)) begin
            rd_word = log_cfg[i];
         end
      end
      if (dp_addr == sle_pkg::OFS_ALM_SEL) begin
         rd_word = {24'h00_0000, alm_sel};
      end
      if (dp_addr == sle_pkg::OFS_STATUS) begin
         rd_word[sle_pkg::ST_TOG +: sle_pkg::N_TOG] = toggle_out;
         rd_word[sle_pkg::ST_LOG +: sle_pkg::N_LOG] = logic_out;
         rd_word[sle_pkg::ST_ALM] = alarm_on;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hrdata_out <= '0;
      end else if (rd_pend) begin
         hrdata_out <= rd_word;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   alarm_drive_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      next_alarm_on |=> (alarm_pwr_out && !alarm_gnd_out
                         && !alarm_pwr_oe_b_out && !alarm_gnd_oe_b_out))
      else $error("alarm not driven while its source is active");
   alarm_float_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      !next_alarm_on |=> (alarm_pwr_oe_b_out && alarm_gnd_oe_b_out))
      else $error("alarm driven while its source is inactive");
   alarm_pair_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      alarm_pwr_oe_b_out == alarm_gnd_oe_b_out)
      else $error("alarm terminals switched apart");
   none_low_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (alm_sel == sle_pkg::SEL_RST) |=> alarm_pwr_oe_b_out)
      else $error("no-source selection did not read low");
   logic_feed_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      $rose(logic_out[0]) |-> src_vec[sle_pkg::SRC_LOG])
      else $error("logic output not visible as a source");
   bus_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      (take && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read data phase not one wait state long");
endmodule
`default_nettype wire

// *** verilog/sle_pkg.sv ***
// constants for the switching logic element fabric: source map, register
// map, field layout and reset values.
// assumes a single 32-bit ahb-lite slave window decoded on haddr[11:0].
`default_nettype none
package sle_pkg;
   // ---------------------------------------------------------------
   // element counts
   // ---------------------------------------------------------------
   localparam int N_TOG = 8;
   localparam int N_LOG = 8;
   localparam int N_BE = 12;
   localparam int N_NET = 16;
   localparam int N_FUNC = 8;
   localparam int N_CH = 16;
   localparam int N_DIO = 16;
   localparam int SEL_W = 8;
   localparam int LUT_W = 8;
   // ---------------------------------------------------------------
   // source index map, index 0 is the constant low source
   // ---------------------------------------------------------------
   localparam int SRC_NONE = 0;
   localparam int SRC_BE_LO = 1;
   localparam int SRC_BE_FL = 13;
   localparam int SRC_BE_HI = 25;
   localparam int SRC_NET = 37;
   localparam int SRC_LOG = 53;
   localparam int SRC_LAT = 61;
   localparam int SRC_TOG = 69;
   localparam int SRC_TMR = 77;
   localparam int SRC_FLS = 85;
   localparam int SRC_CNT = 93;
   localparam int SRC_OC = 101;
   localparam int SRC_TRP = 117;
   localparam int SRC_THM = 133;
   localparam int SRC_DIO = 149;
   localparam int SRC_NUM = 165;
   // ---------------------------------------------------------------
   // register byte offsets and fields
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_TOG_SEL = 12'h000;
   localparam logic [11:0] OFS_LOG_CFG = 12'h020;
   localparam logic [11:0] OFS_ALM_SEL = 12'h040;
   localparam logic [11:0] OFS_STATUS = 12'h044;
   localparam int OFS_STEP = 4;
   localparam int FLD_A = 0;
   localparam int FLD_B = 8;
   localparam int FLD_C = 16;
   localparam int FLD_LUT = 24;
   localparam int ST_TOG = 0;
   localparam int ST_LOG = 8;
   localparam int ST_ALM = 16;
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   // ---------------------------------------------------------------
   // ahb-lite encodings
   // ---------------------------------------------------------------
   localparam int HTRANS_ACT = 1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

// *** verilog/sle_toggle.sv ***
// one toggle latch element: inverts its output on a rising input.
// assumes its input is already on sys_clk_in (selected source).
`default_nettype none
`timescale 1ns/1ps
module sle_toggle (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // element
   input wire logic toggle_in,
   output logic toggle_out
);
   logic prev;

   // ---------------------------------------------------------------
   // edge detect against last sample
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prev <= 1'b0;
      end else begin
         prev <= toggle_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         toggle_out <= 1'b0;
      end else if (toggle_in && !prev) begin
         toggle_out <= ~toggle_out;
      end
      // else hold, falling edge or steady level
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   toggle_rise_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (toggle_in && !prev) |=> (toggle_out != $past(toggle_out)))
      else $error("toggle did not invert on rising input");
   toggle_fall_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (!toggle_in && prev) |=> $stable(toggle_out))
      else $error("toggle changed on falling input");
   toggle_hold_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (toggle_in == prev) [*2] |-> $stable(toggle_out))
      else $error("toggle changed while input steady");
endmodule
`default_nettype wire

// *** verilog/sle_lut.sv ***
// one three-input lookup-table logic element with a registered output.
// assumes inputs and table are on sys_clk_in.
`default_nettype none
`timescale 1ns/1ps
module sle_lut (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // element
   input wire logic a_in,
   input wire logic b_in,
   input wire logic c_in,
   input wire logic [sle_pkg::LUT_W-1:0] lut_in,
   output logic lut_out
);
   // ---------------------------------------------------------------
   // table lookup, first input is the index msb
   // ---------------------------------------------------------------
   // registered so chained elements form no combinational loop
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lut_out <= 1'b0;
      end else begin
         lut_out <= lut_in[{a_in, b_in, c_in}];
      end
   end

   lut_value_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      1'b1 |=> (lut_out == $past(lut_in[{a_in, b_in, c_in}])))
      else $error("logic output not the selected table entry");
   lut_order_a: assert property (
      @(posedge sys_clk_in) disable iff (!rst_b_in)
      (a_in && !b_in && !c_in) |=> (lut_out == $past(lut_in[4])))
      else $error("first input is not the index msb");
endmodule
`default_nettype wire

// *** tb/sle_far_model.sv ***
// far-side model: event input voltage ranges and breaker status flags.
// assumes the bench sets a range code per event input and the flag bits.
`default_nettype none
`timescale 1ns/1ps
module sle_far_model (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // commands: range per input (0 low, 1 float, 2 high), breaker flags
   input wire logic [23:0] rng_in,
   input wire logic [47:0] flag_in,
   // event pins
   output logic [11:0] be_low_out,
   output logic [11:0] be_float_out,
   output logic [11:0] be_high_out,
   // breaker flags
   output logic [15:0] oc_out,
   output logic [15:0] trip_out,
   output logic [15:0] therm_out
);
   // ---------------------------------------------------------------
   // pins
   // ---------------------------------------------------------------
   // an open event input rests in the float range, so reset shows float
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         be_low_out <= 12'h000;
         be_float_out <= 12'hfff;
         be_high_out <= 12'h000;
      end else begin
         for (int i = 0; i < 12; i++) begin
            be_low_out[i] <= rng_in[2*i+:2] == 2'd0;
            be_float_out[i] <= rng_in[2*i+:2] == 2'd1;
            be_high_out[i] <= rng_in[2*i+:2] == 2'd2;
         end
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {therm_out, trip_out, oc_out} <= 48'h0000_0000_0000;
      end else begin
         {therm_out, trip_out, oc_out} <= flag_in;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_switching_logic_elements.sv ***
// self-checking bench for sle_top: random element traffic, alarm sources.
// assumes sle_far_model drives the event and breaker flag pins.
`default_nettype none
`timescale 1ns/1ps
module tb_switching_logic_elements;
   logic sys_clk_in, rst_b_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
   logic [1:0] htrans_in = 2'b00;
   logic [2:0] hsize_in = 3'h2;
   logic [31:0] haddr_in = 32'h0000_0000, hwdata_in = 32'h0000_0000;
   logic [31:0] hrdata_out, rd_s, v;
   logic hready_in, hreadyout_out, hresp_out, hr_s;
   logic [11:0] be_low_in, be_float_in, be_high_in;
   logic [15:0] dio_in = 16'h0000, net_in = 16'h0000;
   logic [15:0] oc_fault_in, tripped_in, therm_in;
   logic [7:0] latch_in = 8'h00, timer_in = 8'h00, flash_in = 8'h00;
   logic [7:0] count_act_in = 8'h00, toggle_out, logic_out;
   logic [7:0] e_tog = 8'h00, e_log = 8'h00, p_net = 8'h00;
   logic alarm_pwr_out, alarm_pwr_oe_b_out, alarm_gnd_out, alarm_gnd_oe_b_out;
   logic [23:0] rng = 24'h55_5555;
   logic [47:0] flag = 48'h0000_0000_0000;
   logic [7:0] lut [8];
   logic [31:0] seed = 32'h0000_0018;
   int err_count = 0, check_count = 0, cyc = 0, ch;
   int base [9] = '{sle_pkg::SRC_BE_LO, sle_pkg::SRC_BE_FL, sle_pkg::SRC_BE_HI,
      sle_pkg::SRC_NET, sle_pkg::SRC_CNT, sle_pkg::SRC_OC, sle_pkg::SRC_TRP,
      sle_pkg::SRC_THM, sle_pkg::SRC_DIO};
   int lim [9] = '{12, 12, 12, 16, 8, 16, 16, 16, 16};
   assign hready_in = hreadyout_out;
   sle_top dut_u (.sys_clk_in, .rst_b_in, .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out,
      .hreadyout_out, .hresp_out, .be_low_in, .be_float_in, .be_high_in,
      .dio_in, .net_in, .latch_in, .timer_in, .flash_in, .count_act_in,
      .oc_fault_in, .tripped_in, .therm_in, .toggle_out, .logic_out,
      .alarm_pwr_out, .alarm_pwr_oe_b_out, .alarm_gnd_out,
      .alarm_gnd_oe_b_out);
   sle_far_model far_u (.sys_clk_in, .rst_b_in, .rng_in(rng), .flag_in(flag),
      .be_low_out(be_low_in), .be_float_out(be_float_in),
      .be_high_out(be_high_in), .oc_out(oc_fault_in),
      .trip_out(tripped_in), .therm_out(therm_in));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   // ready and read data are taken as they stood at the coming edge
   always @(negedge sys_clk_in) begin
      hr_s <= hreadyout_out;
      rd_s <= hrdata_out;
   end
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         print_verdict();
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // logic 7 sees logic 0 and toggle 0 one evaluation late
   function automatic void upd(input logic [7:0] a, b, c, n);
      logic l0, t0;
      l0 = e_log[0];
      t0 = e_tog[0];
      for (int i = 0; i < 7; i++) e_log[i] = lut[i][{a[i], b[i], c[i]}];
      e_log[7] = lut[7][{l0, t0, 1'b0}];
      e_tog = e_tog ^ (n & ~p_net);
      p_net = n;
   endfunction
   function automatic logic [31:0] cfg(input int i);
      if (i == 7) return {lut[7], 8'h00, 8'(sle_pkg::SRC_TOG),
         8'(sle_pkg::SRC_LOG)};
      return {lut[i], 8'(sle_pkg::SRC_FLS + i), 8'(sle_pkg::SRC_TMR + i),
         8'(sle_pkg::SRC_LAT + i)};
   endfunction
   task automatic chk_reg(input string w, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk_out(input string w, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic ahb(input logic wr, input logic [11:0] a,
         input logic [2:0] sz, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk_in);
      hsel_in <= 1'b1;
      htrans_in <= 2'b10;
      haddr_in <= {20'h0_0000, a};
      hwrite_in <= wr;
      hsize_in <= sz;
      do @(posedge sys_clk_in); while (hr_s !== 1'b1);
      htrans_in <= 2'b00;
      hwdata_in <= wd;
      do @(posedge sys_clk_in); while (hr_s !== 1'b1);
      rd = rd_s;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, 3'h2, d, x);
   endtask
   task automatic set_lvl(input int k, input int c, input logic l);
      @(posedge sys_clk_in);
      case (k)
         0, 1, 2: rng[2*c+:2] <= l ? k[1:0] : (k == 2 ? 2'd0 : k[1:0] + 2'd1);
         3: net_in[c] <= l;
         4: count_act_in[c] <= l;
         5, 6, 7: flag[16*(k-5)+c] <= l;
         default: dio_in[c] <= l;
      endcase
   endtask
   // event pins pass a model stage and a synchroniser, hence the margin
   task automatic alm(input logic on);
      for (int k = 0; k < 8 && alarm_pwr_oe_b_out !== !on; k++) begin
         @(posedge sys_clk_in);
         #1;
      end
      chk_out("alarm", {4'h0, on, !on, 1'b0, !on}, {4'h0, alarm_pwr_out,
         alarm_pwr_oe_b_out, alarm_gnd_out, alarm_gnd_oe_b_out});
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      for (int i = 0; i < 18; i++) begin
         ahb(1'b0, 12'(4 * i), 3'h2, 32'h0000_0000, v);
         chk_reg("reset reg", 32'h0000_0000, v);
         chk_out("hresp", 8'h00, {7'h00, hresp_out});
      end
      lut[0] = 8'hd5;
      for (int i = 1; i < 8; i++) lut[i] = xs() & 32'h0000_00ff;
      for (int i = 0; i < 8; i++) begin
         wr(sle_pkg::OFS_TOG_SEL + 12'(4 * i), 32'(sle_pkg::SRC_NET + i));
         wr(sle_pkg::OFS_LOG_CFG + 12'(4 * i), cfg(i));
      end
      ahb(1'b0, sle_pkg::OFS_LOG_CFG + 12'h01c, 3'h2, 32'h0000_0000, v);
      chk_reg("logic cfg", cfg(7), v);
      upd(8'h00, 8'h00, 8'h00, 8'h00);
      upd(8'h00, 8'h00, 8'h00, 8'h00);
      repeat (4) @(posedge sys_clk_in);
      for (int n = 0; n < 200; n++) begin
         v = xs();
         @(posedge sys_clk_in);
         net_in[7:0] <= v[7:0];
         latch_in <= v[15:8];
         timer_in <= v[23:16];
         flash_in <= v[31:24];
         upd(v[15:8], v[23:16], v[31:24], v[7:0]);
         @(posedge sys_clk_in);
         #1;
         chk_out("toggle", e_tog, toggle_out);
         chk_out("logic", e_log, logic_out);
      end
      // logic 7 catches up with the last logic 0 and toggle 0 values
      upd(v[15:8], v[23:16], v[31:24], v[7:0]);
      ahb(1'b0, sle_pkg::OFS_STATUS, 3'h2, 32'h0000_0000, v);
      chk_reg("status", {16'h0000, e_log, e_tog}, v);
      for (int k = 0; k < 9; k++) begin
         ch = int'(xs() % 32'(lim[k]));
         wr(sle_pkg::OFS_ALM_SEL, 32'(base[k] + ch));
         set_lvl(k, ch, 1'b1);
         alm(1'b1);
         set_lvl(k, ch, 1'b0);
         alm(1'b0);
      end
      ahb(1'b1, sle_pkg::OFS_ALM_SEL, 3'h0, 32'h0000_00ff, v);
      ahb(1'b0, sle_pkg::OFS_ALM_SEL, 3'h2, 32'h0000_0000, v);
      chk_reg("alarm sel", 32'(base[8] + ch), v);
      ahb(1'b0, 12'h048, 3'h2, 32'h0000_0000, v);
      chk_reg("unmapped", 32'h0000_0000, v);
      print_verdict();
   end
endmodule
`default_nettype wire
